//--- timer_common_regs.vh
// register map, field positions and reset values of the timer common control
// Summary of operation
// - run register loads E0 on reset, standby
// - reserved high bits read as one
// - run bit n halts or counts channel n
// - sync register loads E0 on reset, standby
// - sync bit joins channel to group preset/clear
// - mode register loads 80 on reset, standby
// - mode bit 6 makes channel 2 quadrature counter
// - four quadrature edge cases count channel 2 down
// - four quadrature edge cases count channel 2 up
// - quadrature ignores channel 2 edge and source
// - clear, compare and flags stay active in quadrature
// - mode bit 5 picks wrap flag condition
// - mode bits 4..0 select pulse mode
// - pulse pin high on match A, low on B
// - combination mode overrides pulse bits 3, 4
`ifndef TIMER_COMMON_REGS_VH
`define TIMER_COMMON_REGS_VH
`define OFS_RUN       12'h000
`define OFS_SYNC      12'h004
`define OFS_MODE      12'h008
`define OFS_FUNC      12'h00C
`define OFS_STATUS    12'h010
`define OFS_MASK      12'h014
`define OFS_CLR_SEL   12'h018
`define OFS_CH_BASE   12'h020
`define CH_STRIDE_LOG 4
`define CH_COUNT_OFS  2'h0
`define CH_GRA_OFS    2'h1
`define CH_GRB_OFS    2'h2
`define RUN_RESET     8'hE0
`define SYNC_RESET    8'hE0
`define MODE_RESET    8'h80
`define FUNC_RESET    8'hC0
`define RUN_RSVD      8'hE0
`define MODE_RSVD     8'h80
`define FUNC_RSVD     8'hC0
`define MODE_QUAD_BIT 6
`define MODE_WRAP_BIT 5
`define FUNC_CMD_HI   5
`define FUNC_CMD_LO   4
`define ST_WRAP_BIT   0
`define ST_HIT_A_LSB  1
`define ST_HIT_B_LSB  6
`define ST_WIDTH      11
`define GR_RESET      16'hFFFF
`define PRESCALE_DIV  4
`endif

//--- timer_channel.v
// one 16-bit timer channel: counter, two comparators, pulse output
`timescale 1ns/1ps
`include "timer_common_regs.vh"
module timer_channel #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         presetn,
	input  wire         run,
	input  wire         step,
	input  wire         down,
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         clr,
	input  wire [W-1:0] cmp_a,
	input  wire [W-1:0] cmp_b,
	input  wire         pwm_en,
	output reg  [W-1:0] count,
	output wire         hit_a,
	output wire         hit_b,
	output wire         wrap_up,
	output wire         wrap_dn,
	output reg          pwm_out
);
	wire         advance;
	wire [W-1:0] next_count;

	// counting only while the run bit is set
	assign advance    = run & step;
	assign next_count = down ? count - {{(W-1){1'b0}}, 1'b1} : count + {{(W-1){1'b0}}, 1'b1};
	assign hit_a      = advance & (count == cmp_a);
	assign hit_b      = advance & (count == cmp_b);
	assign wrap_up    = advance & ~down & (count == {W{1'b1}});
	assign wrap_dn    = advance & down & (count == {W{1'b0}});

	always @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			count <= {W{1'b0}};
		end else if (load) begin
			count <= load_val;
		end else if (clr) begin
			count <= {W{1'b0}};
		end else if (advance) begin
			count <= next_count;
		end
	end

	// low match wins when both compare values coincide
	always @(posedge clk or negedge presetn) begin
		if (!presetn) begin
			pwm_out <= 1'b0;
		end else if (!pwm_en) begin
			pwm_out <= 1'b0;
		end else if (hit_b) begin
			pwm_out <= 1'b0;
		end else if (hit_a) begin
			pwm_out <= 1'b1;
		end
	end
endmodule // timer_channel

//--- timer_common_ctrl.v
// five-channel timer with common run, sync and mode control over apb
`timescale 1ns/1ps
`include "timer_common_regs.vh"
module timer_common_ctrl #(
	parameter NCH      = 5,
	parameter W        = 16,
	parameter PRESCALE = `PRESCALE_DIV
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	input  wire          standby,
	input  wire          ext_clock_pin_a,
	input  wire          ext_clock_pin_b,
	output wire [NCH-1:0] io_pin_a,
	output wire [NCH-1:0] io_pin_a_oe_n,
	output wire          irq
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	reg  [4:0]           run_bits;
	reg  [4:0]           sync_bits;
	reg  [6:0]           mode_bits;
	reg  [1:0]           comb_mode;
	reg  [4:0]           clr_sel;
	reg  [`ST_WIDTH-1:0] status;
	reg  [`ST_WIDTH-1:0] mask;
	reg  [`ST_WIDTH-1:0] status_seen;
	reg  [W-1:0]         gra [0:NCH-1];
	reg  [W-1:0]         grb [0:NCH-1];
	reg  [31:0]          next_rdata;
	reg                  next_err;
	reg                  err_q;

	wire                 setup;
	wire                 access;
	wire                 wr;
	wire                 rd;
	wire                 ch_space;
	wire [2:0]           ch_sel;
	wire [1:0]           ch_reg;
	wire [W-1:0]         cnt [0:NCH-1];
	wire [NCH-1:0]       hit_a;
	wire [NCH-1:0]       hit_b;
	wire [NCH-1:0]       wrap_up;
	wire [NCH-1:0]       wrap_dn;
	wire [NCH-1:0]       pwm_out;
	wire [NCH-1:0]       pwm_en;
	wire [NCH-1:0]       own_clr;
	wire [NCH-1:0]       ch_clr;
	wire [NCH-1:0]       own_load;
	wire [NCH-1:0]       ch_load;
	wire                 group_clr;
	wire                 group_load;
	wire                 quad_mode;
	wire                 wrap_event;
	wire [`ST_WIDTH-1:0] events;

	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign wr       = access & pwrite;
	assign rd       = access & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = access & err_q;
	assign ch_space = (paddr >= `OFS_CH_BASE) &&
	                  (paddr[11:`CH_STRIDE_LOG] < (`OFS_CH_BASE >> `CH_STRIDE_LOG) + NCH);
	assign ch_sel   = paddr[`CH_STRIDE_LOG+2:`CH_STRIDE_LOG] - 3'h2;
	assign ch_reg   = paddr[3:2];

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// standby restores every control register to its reset value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_bits  <= 5'h00;
			sync_bits <= 5'h00;
			mode_bits <= 7'h00;
			comb_mode <= 2'h0;
			clr_sel   <= 5'h00;
			mask      <= {`ST_WIDTH{1'b0}};
		end else if (standby) begin
			run_bits  <= 5'h00;
			sync_bits <= 5'h00;
			mode_bits <= 7'h00;
			comb_mode <= 2'h0;
			clr_sel   <= 5'h00;
			mask      <= {`ST_WIDTH{1'b0}};
		end else if (wr) begin
			case (paddr)
			`OFS_RUN: begin
				run_bits <= pwdata[4:0];
			end
			`OFS_SYNC: begin
				sync_bits <= pwdata[4:0];
			end
			`OFS_MODE: begin
				mode_bits <= pwdata[6:0];
			end
			`OFS_FUNC: begin
				comb_mode <= pwdata[`FUNC_CMD_HI:`FUNC_CMD_LO];
			end
			`OFS_MASK: begin
				mask <= pwdata[`ST_WIDTH-1:0];
			end
			`OFS_CLR_SEL: begin
				clr_sel <= pwdata[4:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// compare registers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gen_gr
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gra[g] <= `GR_RESET;
					grb[g] <= `GR_RESET;
				end else if (wr && ch_space && ch_sel == g) begin
					if (ch_reg == `CH_GRA_OFS) begin
						gra[g] <= pwdata[W-1:0];
					end
					if (ch_reg == `CH_GRB_OFS) begin
						grb[g] <= pwdata[W-1:0];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// prescaler tick for internal clock source
	// ----------------------------------------------------------------
	reg [7:0] div_cnt;
	wire      tick;

	assign tick = (div_cnt == PRESCALE[7:0] - 8'h01);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
		end else if (tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// quadrature decoder for channel 2
	// ----------------------------------------------------------------
	reg  pa_q;
	reg  pb_q;
	wire a_rise;
	wire a_fall;
	wire b_rise;
	wire b_fall;
	wire quad_up;
	wire quad_dn;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_q <= 1'b0;
			pb_q <= 1'b0;
		end else begin
			pa_q <= ext_clock_pin_a;
			pb_q <= ext_clock_pin_b;
		end
	end

	assign quad_mode = mode_bits[`MODE_QUAD_BIT];
	assign a_rise    = ext_clock_pin_a & ~pa_q;
	assign a_fall    = ~ext_clock_pin_a & pa_q;
	assign b_rise    = ext_clock_pin_b & ~pb_q;
	assign b_fall    = ~ext_clock_pin_b & pb_q;
	assign quad_dn   = (a_rise & ~ext_clock_pin_b) | (b_rise & ext_clock_pin_a) |
	                   (a_fall & ext_clock_pin_b) | (b_fall & ~ext_clock_pin_a);
	assign quad_up   = (a_rise & ext_clock_pin_b) | (a_fall & ~ext_clock_pin_b) |
	                   (b_fall & ext_clock_pin_a) |
	                   (b_rise & ~ext_clock_pin_a);

	// ----------------------------------------------------------------
	// clear and preset, independent or synchronous
	// ----------------------------------------------------------------
	assign own_clr    = clr_sel & hit_a;
	assign group_clr  = |(own_clr & sync_bits);
	assign ch_clr     = own_clr | (sync_bits & {NCH{group_clr}});
	assign group_load = |(own_load & sync_bits);
	assign ch_load    = own_load | (sync_bits & {NCH{group_load}});

	// combination mode takes channels 3 and 4 away from plain pulse mode
	assign pwm_en[2:0] = mode_bits[2:0];
	assign pwm_en[3]   = mode_bits[3] & ~comb_mode[1];
	assign pwm_en[4]   = mode_bits[4] & ~comb_mode[1];

	generate
		for (g = 0; g < NCH; g = g + 1) begin : gen_ch
			wire step_g;
			wire down_g;
			if (g == 2) begin : g_quad
				// quadrature replaces edge and source selection
				assign step_g = quad_mode ? (quad_up | quad_dn) : tick;
				assign down_g = quad_mode & quad_dn;
			end else begin : g_norm
				assign step_g = tick;
				assign down_g = 1'b0;
			end
			assign own_load[g] = wr && ch_space && ch_sel == g && ch_reg == `CH_COUNT_OFS;
			timer_channel #(
				.W(W)
			) u_ch (
				.clk      (pclk),
				.presetn  (presetn),
				.run      (run_bits[g]),
				.step     (step_g),
				.down     (down_g),
				.load     (ch_load[g]),
				.load_val (pwdata[W-1:0]),
				.clr      (ch_clr[g]),
				.cmp_a    (gra[g]),
				.cmp_b    (grb[g]),
				.pwm_en   (pwm_en[g]),
				.count    (cnt[g]),
				.hit_a    (hit_a[g]),
				.hit_b    (hit_b[g]),
				.wrap_up  (wrap_up[g]),
				.wrap_dn  (wrap_dn[g]),
				.pwm_out  (pwm_out[g])
			);
		end
	endgenerate

	// pin a of a pulse-mode channel is driven, else released
	assign io_pin_a      = pwm_out;
	assign io_pin_a_oe_n = ~pwm_en;

	// ----------------------------------------------------------------
	// status, mask and interrupt
	// ----------------------------------------------------------------
	assign wrap_event = wrap_up[2] | (wrap_dn[2] & ~mode_bits[`MODE_WRAP_BIT]);
	assign events     = {hit_b, hit_a, wrap_event};

	// only bits captured by the read are cleared; a new event wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= {`ST_WIDTH{1'b0}};
		end else if (rd && paddr == `OFS_STATUS) begin
			status <= (status & ~status_seen) | events;
		end else begin
			status <= status | events;
		end
	end

	assign irq = |(status & mask);

	// ----------------------------------------------------------------
	// read path, captured in the setup cycle
	// ----------------------------------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		if (ch_space) begin
			case (ch_reg)
			`CH_COUNT_OFS: begin
				next_rdata[W-1:0] = cnt[ch_sel];
			end
			`CH_GRA_OFS: begin
				next_rdata[W-1:0] = gra[ch_sel];
			end
			`CH_GRB_OFS: begin
				next_rdata[W-1:0] = grb[ch_sel];
			end
			default: begin
				next_err = 1'b1;
			end
			endcase
		end else begin
			case (paddr)
			`OFS_RUN: begin
				next_rdata[7:0] = `RUN_RSVD | {3'h0, run_bits};
			end
			`OFS_SYNC: begin
				next_rdata[7:0] = `RUN_RSVD | {3'h0, sync_bits};
			end
			`OFS_MODE: begin
				next_rdata[7:0] = `MODE_RSVD | {1'b0, mode_bits};
			end
			`OFS_FUNC: begin
				next_rdata[7:0] = `FUNC_RSVD | {2'h0, comb_mode, 4'h0};
			end
			`OFS_STATUS: begin
				next_rdata[`ST_WIDTH-1:0] = status;
			end
			`OFS_MASK: begin
				next_rdata[`ST_WIDTH-1:0] = mask;
			end
			`OFS_CLR_SEL: begin
				next_rdata[4:0] = clr_sel;
			end
			default: begin
				next_err = 1'b1;
			end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h0000_0000;
			err_q       <= 1'b0;
			status_seen <= {`ST_WIDTH{1'b0}};
		end else if (setup) begin
			prdata      <= pwrite ? 32'h0000_0000 : next_rdata;
			err_q       <= next_err;
			status_seen <= status;
		end
	end
endmodule // timer_common_ctrl

//--- quad_encoder_model.sv
// quadrature encoder standing at the two external clock pins
`timescale 1ns/1ps
module quad_encoder_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic step,
	input  wire logic up,
	output wire logic pin_a,
	output wire logic pin_b
);
	logic [1:0] phase;

	// gray walk 00 01 11 10 forward; reverse walk counts down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase <= 2'h0;
		else if (step)
			phase <= up ? phase + 2'h1 : phase - 2'h1;
	end
	assign pin_a = phase[1];
	assign pin_b = phase[1] ^ phase[0];
endmodule // quad_encoder_model

//--- timer_common_checker.sv
// port checker for the timer common control
`timescale 1ns/1ps
module timer_common_checker #(
	parameter NCH      = 5,
	parameter W        = 16,
	parameter PRESCALE = 4
) (
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    prdata,
	input wire logic           pslverr,
	input wire logic           standby,
	input wire logic [NCH-1:0] io_pin_a,
	input wire logic [NCH-1:0] io_pin_a_oe_n,
	input wire logic           irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_setup = psel && !penable && !pwrite;

	// ----------------------------------------
	// register and pin relations
	// ----------------------------------------
	sb_run_a: assert property (standby && $past(standby) && rd_setup && paddr == 12'h000
		|=> prdata[7:0] == 8'hE0) else $error("run register not reset in standby");
	sb_sync_a: assert property (standby && $past(standby) && rd_setup && paddr == 12'h004
		|=> prdata[7:0] == 8'hE0) else $error("sync register not reset in standby");
	sb_mode_a: assert property (standby && $past(standby) && rd_setup && paddr == 12'h008
		|=> prdata[7:0] == 8'h80) else $error("mode register not reset in standby");
	rsvd_ctl_a: assert property (rd_setup && paddr[11:3] == 9'h000
		|=> prdata[7:5] == 3'h7) else $error("reserved run or sync bits not one");
	rsvd_mode_a: assert property (rd_setup && paddr == 12'h008
		|=> prdata[7]) else $error("reserved mode bit not one");
	oe_off_a: assert property (standby |-> ##2 (&io_pin_a_oe_n))
		else $error("pulse pin still enabled after standby");
	pin_idle_a: assert property ((io_pin_a & io_pin_a_oe_n & $past(io_pin_a_oe_n)) == '0)
		else $error("pulse pin high while not in pulse mode");
	irq_off_a: assert property (standby |-> ##2 !irq)
		else $error("interrupt high with mask cleared");
	err_resp_a: assert property (psel && penable && paddr == 12'h02C |-> pslverr)
		else $error("no error response on unmapped address");
endmodule // timer_common_checker

bind timer_common_ctrl timer_common_checker #(.NCH(NCH), .W(W), .PRESCALE(PRESCALE)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr), .standby(standby),
	.io_pin_a(io_pin_a), .io_pin_a_oe_n(io_pin_a_oe_n), .irq(irq));

//--- tb_top.sv
// self-checking testbench of the timer common control
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, standby, step, up, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, pin_a, pin_b;
	wire  [4:0]  io_pin_a, io_pin_a_oe_n;
	int          num_errors = 0;
	int          n_compared = 0;

	timer_common_ctrl #(.PRESCALE(1)) u_timer_common_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
		.ext_clock_pin_a(pin_a), .ext_clock_pin_b(pin_b), .io_pin_a(io_pin_a),
		.io_pin_a_oe_n(io_pin_a_oe_n), .irq(irq));
	quad_encoder_model u_quad_encoder_model (.pclk(pclk), .presetn(presetn), .step(step),
		.up(up), .pin_a(pin_a), .pin_b(pin_b));

	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end

	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			num_errors++;
			end_sim();
		end
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(0, a, 32'h0);
		chk(nm, q, e);
	endtask

	task enc(input logic dir);
		step <= 1;
		up <= dir;
		@(posedge pclk);
		step <= 0;
		repeat (6) @(posedge pclk);
	endtask

	task wait_pin(input logic v);
		int i;
		for (i = 0; i < 300 && io_pin_a[0] !== v; i++) @(negedge pclk);
		if (i == 300) begin
			num_errors++;
			end_sim();
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset_rsvd;
		rd(12'h000, 32'hE0, "run reset");
		rd(12'h004, 32'hE0, "sync reset");
		rd(12'h008, 32'h80, "mode reset");
		wr(12'h004, 32'h1F);
		rd(12'h004, 32'hFF, "sync bits");
		wr(12'h008, 32'h00);
		rd(12'h008, 32'h80, "mode rsvd");
	endtask

	task t_run;
		wr(12'h000, 32'h01);
		repeat (20) @(posedge pclk);
		wr(12'h000, 32'h00);
		apb(0, 12'h020, 32'h0);
		chk("ch0 counted", q != 0, 1);
		rd(12'h020, q, "ch0 halted");
		rd(12'h030, 32'h0, "ch1 idle");
	endtask

	task t_sync;
		wr(12'h004, 32'h03);
		wr(12'h020, 32'h1234);
		rd(12'h030, 32'h1234, "ch1 synced");
		rd(12'h050, 32'h0, "ch3 alone");
		wr(12'h004, 32'h00);
		wr(12'h020, 32'h5);
		rd(12'h030, 32'h1234, "ch1 apart");
	endtask

	task t_quad;
		wr(12'h008, 32'h40);
		wr(12'h040, 32'h10);
		wr(12'h000, 32'h04);
		wr(12'h014, 32'h01);
		apb(0, 12'h010, 32'h0);
		repeat (4) enc(1);
		rd(12'h040, 32'h14, "quad up");
		repeat (4) enc(0);
		rd(12'h040, 32'h10, "quad down");
		wr(12'h040, 32'h0);
		enc(0);
		chk("irq on wrap", irq, 1);
		rd(12'h040, 32'hFFFF, "underflow");
		apb(0, 12'h010, 32'h0);
		chk("underflow flag", q & 1, 1);
		@(negedge pclk);
		chk("irq cleared", irq, 0);
		wr(12'h008, 32'h60);
		wr(12'h040, 32'h0);
		enc(0);
		apb(0, 12'h010, 32'h0);
		chk("no underflow flag", q & 1, 0);
		enc(1);
		apb(0, 12'h010, 32'h0);
		chk("overflow flag", q & 1, 1);
		wr(12'h044, 32'h2);
		wr(12'h018, 32'h04);
		wr(12'h030, 32'h77);
		wr(12'h040, 32'h0);
		wr(12'h004, 32'h06);
		repeat (3) enc(1);
		rd(12'h040, 32'h0, "quad clear");
		rd(12'h030, 32'h0, "sync clear");
		wr(12'h004, 32'h00);
		wr(12'h018, 32'h00);
		wr(12'h000, 32'h00);
	endtask

	task t_pwm;
		wr(12'h024, 32'h10);
		wr(12'h028, 32'h40);
		wr(12'h020, 32'h0);
		wr(12'h008, 32'h01);
		@(negedge pclk);
		chk("oe ch0", io_pin_a_oe_n, 32'h1E);
		chk("pin idle", io_pin_a[0], 0);
		wr(12'h000, 32'h01);
		wait_pin(1);
		repeat (32) @(negedge pclk);
		chk("pin high", io_pin_a[0], 1);
		wait_pin(0);
		wr(12'h000, 32'h00);
		rd(12'h020, 32'h44, "fall at B");
		chk("pin low", io_pin_a[0], 0);
	endtask

	task t_combo;
		wr(12'h008, 32'h18);
		wr(12'h00C, 32'h20);
		@(negedge pclk);
		chk("combo oe", io_pin_a_oe_n[4:3], 2'b11);
		wr(12'h00C, 32'h00);
		@(negedge pclk);
		chk("pulse oe", io_pin_a_oe_n[4:3], 2'b00);
		apb(0, 12'h02C, 32'h0);
		chk("bad addr err", err, 1);
		chk("bad addr data", q, 0);
	endtask

	task t_standby;
		wr(12'h000, 32'h1F);
		wr(12'h004, 32'h1F);
		standby <= 1;
		rd(12'h000, 32'hE0, "run standby");
		rd(12'h004, 32'hE0, "sync standby");
		rd(12'h008, 32'h80, "mode standby");
		chk("oe standby", io_pin_a_oe_n, 32'h1F);
		standby <= 0;
		rd(12'h000, 32'hE0, "run after");
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		standby = 0;
		step = 0;
		up = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_reset_rsvd();
		t_run();
		t_sync();
		t_quad();
		t_pwm();
		t_combo();
		t_standby();
		end_sim();
	end
endmodule // tb_top
